//--- core/ard_defs.vh
// Address map, region codes and memory type codes for the region decoder
`ifndef ARD_DEFS_VH
`define ARD_DEFS_VH

`define ARD_RGN_NONE 3'h0
`define ARD_RGN_FLASH 3'h1
`define ARD_RGN_SRAM 3'h2
`define ARD_RGN_SRAM_ALIAS 3'h3
`define ARD_RGN_PERIPH 3'h4
`define ARD_RGN_PERIPH_ALIAS 3'h5
`define ARD_RGN_PPB 3'h6

`define ARD_TYPE_NORMAL 2'h0
`define ARD_TYPE_DEVICE 2'h1
`define ARD_TYPE_STRONG 2'h2

`define ARD_AREA_CODE 3'h0
`define ARD_AREA_SRAM 3'h1
`define ARD_AREA_PERIPH 3'h2
`define ARD_AREA_XRAM_LO 3'h3
`define ARD_AREA_XRAM_HI 3'h4
`define ARD_AREA_XDEV_LO 3'h5
`define ARD_AREA_XDEV_HI 3'h6

`define ARD_FLASH_LO 32'h0000_0000
`define ARD_FLASH_HI 32'h0003_FFFF
`define ARD_SRAM_LO 32'h2000_0000
`define ARD_SRAM_HI 32'h2000_FFFF
`define ARD_SALIAS_LO 32'h2200_0000
`define ARD_SALIAS_HI 32'h221F_FFFF
`define ARD_PERI_LO 32'h4000_0000
`define ARD_PERI_HI 32'h400F_FFFF
`define ARD_PALIAS_LO 32'h4200_0000
`define ARD_PALIAS_HI 32'h43FF_FFFF
`define ARD_PPB_LO 32'hE000_0000
`define ARD_PPB_HI 32'hE00F_FFFF
`define ARD_DBG_HI 32'hE000_2FFF
`define ARD_SYS_LO 32'hE000_E000
`define ARD_SYS_HI 32'hE000_EFFF
`define ARD_TPIU_LO 32'hE004_0000
`define ARD_TPIU_HI 32'hE004_0FFF

`endif

//--- core/ard_map_decode.v
// Combinational address to region, memory type and execute-never decode
`timescale 1ns/1ps
`default_nettype none
`include "ard_defs.vh"

module ard_map_decode (
  input wire [31:0] addr,
  input wire mpu_enable,
  input wire mpu_hit,
  input wire [1:0] mpu_type,
  input wire mpu_xn,
  output reg [2:0] region,
  output reg [1:0] mem_type,
  output reg execute_never,
  output reg reserved
);

  function in_rng;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Fixed map, no remap state at all
  always @* begin
    region = `ARD_RGN_NONE;
    if (in_rng(addr, `ARD_FLASH_LO, `ARD_FLASH_HI)) region = `ARD_RGN_FLASH;
    if (in_rng(addr, `ARD_SRAM_LO, `ARD_SRAM_HI)) region = `ARD_RGN_SRAM;
    if (in_rng(addr, `ARD_SALIAS_LO, `ARD_SALIAS_HI)) region = `ARD_RGN_SRAM_ALIAS;
    if (in_rng(addr, `ARD_PERI_LO, `ARD_PERI_HI)) region = `ARD_RGN_PERIPH;
    if (in_rng(addr, `ARD_PALIAS_LO, `ARD_PALIAS_HI)) region = `ARD_RGN_PERIPH_ALIAS;
    if (in_rng(addr, `ARD_PPB_LO, `ARD_DBG_HI) || in_rng(addr, `ARD_SYS_LO, `ARD_SYS_HI) ||
        in_rng(addr, `ARD_TPIU_LO, `ARD_TPIU_HI)) region = `ARD_RGN_PPB;
    reserved = (region == `ARD_RGN_NONE);
    case (addr[31:29])
      `ARD_AREA_CODE, `ARD_AREA_SRAM, `ARD_AREA_XRAM_LO, `ARD_AREA_XRAM_HI: begin
        mem_type = `ARD_TYPE_NORMAL;
        execute_never = 1'b0;
      end
      `ARD_AREA_PERIPH, `ARD_AREA_XDEV_LO, `ARD_AREA_XDEV_HI: begin
        mem_type = `ARD_TYPE_DEVICE;
        execute_never = 1'b1;
      end
      default: begin
        mem_type = `ARD_TYPE_STRONG;
        execute_never = 1'b1;
      end
    endcase
    // Protection unit wins on attributes but never makes a hole usable
    if (mpu_enable && mpu_hit) begin
      mem_type = mpu_type;
      execute_never = mpu_xn;
    end
  end

endmodule // ard_map_decode
`default_nettype wire

//--- core/ard_top.v
// Region decoder with access ordering, posted Device writes and barriers
`timescale 1ns/1ps
`default_nettype none
`include "ard_defs.vh"
// Function
// - Fixed 4 GB map, identical after every reset, no remapping.
// - Reserved data accesses and executable-space fetches answer with a bus fault, no data, no store.
// - SRAM and its alias window are routed to their own regions.
// - Peripheral alias window covers the low peripheral megabyte.
// - Code region is Normal and executable for fetches and data.
// - SRAM region is Normal and executable for fetches and data.
// - Peripheral region and its alias are Device and execute-never.
// - External device space is Device and execute-never.
// - Private peripheral bus space is Strongly Ordered, execute-never.
// - Normal accesses may pass buffered Device writes.
// - Device accesses keep order against Device and Strongly Ordered.
// - Strongly Ordered accesses keep order against every access.
// - Device writes may post; Strongly Ordered writes ack at target.
// - Execute-never fetches blocked; fault only when executed.
// - First Device or Strongly Ordered access reaches target first.
// - Enabled protection unit overrides type and execute-never.
// - Speculative instruction fetches are accepted like any fetch.
// - Memory barrier drains all before any later access issues.
// - Sync barrier drains all before later instructions execute.
// - Instruction barrier drains, then flushes fetched instructions.
// - Priority change committed when a following sync barrier ends.
// - Strongly Ordered accesses are ordered without any barrier.

module ard_top #(
  parameter DW = 32
) (
  input wire clk,
  input wire sys_rst,
  input wire mpu_enable,
  input wire ibus_mpu_hit,
  input wire [1:0] ibus_mpu_type,
  input wire ibus_mpu_xn,
  input wire dbus_mpu_hit,
  input wire [1:0] dbus_mpu_type,
  input wire dbus_mpu_xn,
  input wire ibus_req,
  input wire [31:0] ibus_addr,
  output reg ibus_done,
  output reg ibus_fault,
  output reg ibus_xn_tag,
  output reg [DW-1:0] ibus_rdata,
  input wire exec_valid,
  input wire exec_xn_tag,
  output reg exec_fault,
  input wire dbus_req,
  input wire [31:0] dbus_addr,
  input wire dbus_write,
  input wire [DW-1:0] dbus_wdata,
  output reg dbus_done,
  output reg dbus_fault,
  output reg [DW-1:0] dbus_rdata,
  input wire data_memory_barrier,
  input wire data_sync_barrier,
  input wire instruction_sync_barrier,
  output reg barrier_done,
  output reg exec_hold,
  output reg fetch_flush,
  output reg prio_commit,
  output reg posted_err,
  output reg tgt_req,
  output reg [31:0] tgt_addr,
  output reg tgt_write,
  output reg [DW-1:0] tgt_wdata,
  output reg [2:0] tgt_region,
  output reg [1:0] tgt_type,
  input wire tgt_ack,
  input wire tgt_err,
  input wire [DW-1:0] tgt_rdata
);

  localparam ST_IDLE = 2'h0;
  localparam ST_FRONT = 2'h1;
  localparam ST_DRAIN = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg own_d_reg;
  reg buf_full_reg;
  reg [31:0] buf_addr_reg;
  reg [DW-1:0] buf_data_reg;
  reg [2:0] buf_rgn_reg;
  reg dmb_pend_reg;
  reg dsb_pend_reg;
  reg isb_pend_reg;

  wire [2:0] i_rgn;
  wire [1:0] i_type;
  wire i_xn;
  wire i_resv;
  wire [2:0] d_rgn;
  wire [1:0] d_type;
  wire d_xn;
  wire d_resv;

  // Device and Strongly Ordered both take part in the ordering rules
  function is_ordered;
    input [1:0] mtype;
    begin
      is_ordered = (mtype != `ARD_TYPE_NORMAL);
    end
  endfunction

  // A failed target access hands back zero rather than stale bus data
  function [DW-1:0] ans_data;
    input err;
    input [DW-1:0] rdata;
    begin
      ans_data = err ? {DW{1'b0}} : rdata;
    end
  endfunction

  // Both masters decode in the same cycle their address is shown
  ard_map_decode u_idec (
    .addr(ibus_addr),
    .mpu_enable(mpu_enable),
    .mpu_hit(ibus_mpu_hit),
    .mpu_type(ibus_mpu_type),
    .mpu_xn(ibus_mpu_xn),
    .region(i_rgn),
    .mem_type(i_type),
    .execute_never(i_xn),
    .reserved(i_resv)
  );

  ard_map_decode u_ddec (
    .addr(dbus_addr),
    .mpu_enable(mpu_enable),
    .mpu_hit(dbus_mpu_hit),
    .mpu_type(dbus_mpu_type),
    .mpu_xn(dbus_mpu_xn),
    .region(d_rgn),
    .mem_type(d_type),
    .execute_never(d_xn),
    .reserved(d_resv)
  );

  wire idle = (state_reg == ST_IDLE);
  wire bar_pend = dmb_pend_reg | dsb_pend_reg | isb_pend_reg;

  // Done is still high while the master swaps its request, so skip it
  wire d_ok = idle & dbus_req & ~dbus_done & ~bar_pend;
  wire d_ord = is_ordered(d_type);
  // Ordered access must see the buffered Device write land first
  wire d_wait = buf_full_reg & d_ord;
  wire act_dfault = d_ok & d_resv;
  // Only Device writes post; Strongly Ordered writes must reach the target
  wire act_dpost = d_ok & ~d_resv & ~buf_full_reg & dbus_write &
                   (d_type == `ARD_TYPE_DEVICE);
  wire act_dissue = d_ok & ~d_resv & ~d_wait & ~act_dpost;

  // Speculative and branch-target fetches take the same path
  wire i_ok = idle & ~d_ok & ibus_req & ~ibus_done & ~bar_pend;
  // Fetches from ordered space also wait for the posted write
  wire i_wait = buf_full_reg & is_ordered(i_type);
  wire act_ixn = i_ok & i_xn;
  wire act_ifault = i_ok & ~i_xn & i_resv;
  wire act_iissue = i_ok & ~i_xn & ~i_resv & ~i_wait;

  wire act_drain = idle & buf_full_reg & ~act_dfault & ~act_dissue &
                   ~act_ixn & ~act_ifault & ~act_iissue;
  // Single outstanding transaction, so an empty buffer means all done
  wire act_bar = idle & bar_pend & ~buf_full_reg;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (act_dissue || act_iissue)
          state_next = ST_FRONT;
        else if (act_drain)
          state_next = ST_DRAIN;
      end
      ST_FRONT: begin
        if (tgt_ack)
          state_next = ST_IDLE;
      end
      ST_DRAIN: begin
        if (tgt_ack)
          state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      own_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (act_dissue)
        own_d_reg <= 1'b1;
      else if (act_iissue)
        own_d_reg <= 1'b0;
    end
  end

  // Posted Device write buffer, one entry
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_full_reg <= 1'b0;
      buf_addr_reg <= 32'h0000_0000;
      buf_data_reg <= {DW{1'b0}};
      buf_rgn_reg <= `ARD_RGN_NONE;
    end else begin
      if (act_dpost) begin
        buf_full_reg <= 1'b1;
        buf_addr_reg <= dbus_addr;
        buf_data_reg <= dbus_wdata;
        buf_rgn_reg <= d_rgn;
      end else if (state_reg == ST_DRAIN && tgt_ack) begin
        buf_full_reg <= 1'b0;
      end
    end
  end

  // Target side request, held until acknowledged
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgt_req <= 1'b0;
      tgt_addr <= 32'h0000_0000;
      tgt_write <= 1'b0;
      tgt_wdata <= {DW{1'b0}};
      tgt_region <= `ARD_RGN_NONE;
      tgt_type <= `ARD_TYPE_NORMAL;
    end else begin
      if (act_dissue) begin
        tgt_req <= 1'b1;
        tgt_addr <= dbus_addr;
        tgt_write <= dbus_write;
        tgt_wdata <= dbus_wdata;
        tgt_region <= d_rgn;
        tgt_type <= d_type;
      end else if (act_iissue) begin
        tgt_req <= 1'b1;
        tgt_addr <= ibus_addr;
        tgt_write <= 1'b0;
        tgt_wdata <= {DW{1'b0}};
        tgt_region <= i_rgn;
        tgt_type <= i_type;
      end else if (act_drain) begin
        tgt_req <= 1'b1;
        tgt_addr <= buf_addr_reg;
        tgt_write <= 1'b1;
        tgt_wdata <= buf_data_reg;
        tgt_region <= buf_rgn_reg;
        tgt_type <= `ARD_TYPE_DEVICE;
      end else if (tgt_ack) begin
        tgt_req <= 1'b0;
      end
    end
  end

  // Front-door answer goes back to whichever master owns the access
  wire front_ack = (state_reg == ST_FRONT) & tgt_ack;

  // Data master answers; Strongly Ordered writes wait for the target
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbus_done <= 1'b0;
      dbus_fault <= 1'b0;
      dbus_rdata <= {DW{1'b0}};
    end else begin
      dbus_done <= act_dfault | act_dpost | (front_ack & own_d_reg);
      dbus_fault <= act_dfault | (front_ack & own_d_reg & tgt_err);
      if (front_ack && own_d_reg)
        dbus_rdata <= ans_data(tgt_err, tgt_rdata);
      else if (act_dfault || act_dpost)
        dbus_rdata <= {DW{1'b0}};
    end
  end

  // Instruction master answers; blocked fetches only carry a tag
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ibus_done <= 1'b0;
      ibus_fault <= 1'b0;
      ibus_xn_tag <= 1'b0;
      ibus_rdata <= {DW{1'b0}};
    end else begin
      ibus_done <= act_ixn | act_ifault | (front_ack & ~own_d_reg);
      ibus_fault <= act_ifault | (front_ack & ~own_d_reg & tgt_err);
      ibus_xn_tag <= act_ixn;
      if (front_ack && !own_d_reg)
        ibus_rdata <= ans_data(tgt_err, tgt_rdata);
      else if (act_ixn || act_ifault)
        ibus_rdata <= {DW{1'b0}};
    end
  end

  // A prefetched but discarded blocked fetch never faults
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      exec_fault <= 1'b0;
    else
      exec_fault <= exec_valid & exec_xn_tag;
  end

  // Posted writes cannot report back, so flag a lost one
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      posted_err <= 1'b0;
    else
      posted_err <= (state_reg == ST_DRAIN) & tgt_ack & tgt_err;
  end

  // Barrier pending flags; a new barrier wins over completion
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmb_pend_reg <= 1'b0;
      dsb_pend_reg <= 1'b0;
      isb_pend_reg <= 1'b0;
    end else begin
      dmb_pend_reg <= data_memory_barrier | (dmb_pend_reg & ~act_bar);
      dsb_pend_reg <= data_sync_barrier | (dsb_pend_reg & ~act_bar);
      isb_pend_reg <= instruction_sync_barrier | (isb_pend_reg & ~act_bar);
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      barrier_done <= 1'b0;
      exec_hold <= 1'b0;
      fetch_flush <= 1'b0;
      prio_commit <= 1'b0;
    end else begin
      barrier_done <= act_bar;
      // Execution stalls from the sync barrier until it completes
      exec_hold <= data_sync_barrier | (dsb_pend_reg & ~act_bar);
      fetch_flush <= act_bar & isb_pend_reg;
      prio_commit <= act_bar & dsb_pend_reg;
    end
  end

endmodule // ard_top
`default_nettype wire

//--- test/ard_properties.sv
// Concurrent checks on the ports of the region decoder
`timescale 1ns/1ps
`default_nettype none
`include "ard_defs.vh"
module ard_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mpu_enable,
  input wire logic ibus_req,
  input wire logic [31:0] ibus_addr,
  input wire logic ibus_done,
  input wire logic ibus_xn_tag,
  input wire logic exec_valid,
  input wire logic exec_xn_tag,
  input wire logic exec_fault,
  input wire logic dbus_req,
  input wire logic [31:0] dbus_addr,
  input wire logic dbus_write,
  input wire logic dbus_done,
  input wire logic dbus_fault,
  input wire logic data_sync_barrier,
  input wire logic instruction_sync_barrier,
  input wire logic barrier_done,
  input wire logic exec_hold,
  input wire logic fetch_flush,
  input wire logic tgt_req,
  input wire logic [31:0] tgt_addr,
  input wire logic [2:0] tgt_region,
  input wire logic [1:0] tgt_type,
  input wire logic tgt_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  function automatic logic inr(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return a >= lo && a <= hi;
  endfunction
  // Only the spans past flash, past the peripheral alias and past the TPIU; SRAM and private bus holes are left to the bench, peripheral holes go unchecked
  function automatic logic rsv(input logic [31:0] a);
    return inr(a, 32'h0004_0000, 32'h1FFF_FFFF) || inr(a, 32'h4400_0000, 32'hDFFF_FFFF)
      || a >= 32'hE004_1000;
  endfunction
  a_req_held: assert property (tgt_req && !tgt_ack |=> tgt_req && $stable(tgt_addr))
    else $error("target request dropped or changed before ack");
  a_sram_route: assert property (tgt_req && !mpu_enable && inr(tgt_addr, `ARD_SRAM_LO,
    `ARD_SALIAS_HI) |-> tgt_type == `ARD_TYPE_NORMAL && tgt_region ==
    (inr(tgt_addr, `ARD_SALIAS_LO, `ARD_SALIAS_HI) ? `ARD_RGN_SRAM_ALIAS : `ARD_RGN_SRAM))
    else $error("SRAM window routed wrongly");
  a_periph_dev: assert property (tgt_req && !mpu_enable && inr(tgt_addr, `ARD_PERI_LO,
    `ARD_PALIAS_HI) |-> tgt_type == `ARD_TYPE_DEVICE && tgt_region ==
    (inr(tgt_addr, `ARD_PALIAS_LO, `ARD_PALIAS_HI) ? `ARD_RGN_PERIPH_ALIAS : `ARD_RGN_PERIPH))
    else $error("peripheral window routed wrongly");
  a_ppb_strong: assert property (tgt_req && !mpu_enable && inr(tgt_addr, `ARD_PPB_LO, `ARD_PPB_HI)
    |-> tgt_type == `ARD_TYPE_STRONG && tgt_region == `ARD_RGN_PPB)
    else $error("private bus not strongly ordered");
  a_resv_fault: assert property (dbus_req && dbus_done && rsv(dbus_addr) |-> dbus_fault)
    else $error("reserved data access without fault");
  a_xn_fetch: assert property (ibus_req && ibus_done && !mpu_enable
    && inr(ibus_addr, `ARD_PERI_LO, `ARD_PERI_HI) |-> ibus_xn_tag)
    else $error("peripheral fetch not blocked");
  a_exec_fault: assert property (exec_valid && exec_xn_tag |=> exec_fault)
    else $error("blocked instruction executed without fault");
  a_so_ack_first: assert property (dbus_req && dbus_write && dbus_done
    && inr(dbus_addr, `ARD_SYS_LO, `ARD_SYS_HI) |-> $past(tgt_ack))
    else $error("strongly ordered write answered before target");
  a_dsb_hold: assert property (data_sync_barrier |=> exec_hold)
    else $error("sync barrier did not hold execution");
  a_drained_done: assert property (barrier_done |-> !tgt_req && !$past(tgt_req))
    else $error("barrier completed with traffic outstanding");
  a_isb_flush: assert property (instruction_sync_barrier |-> ##[1:40] fetch_flush)
    else $error("instruction barrier gave no flush");
endmodule // ard_checker
`default_nettype wire

//--- test/ard_tgt_model.sv
// Behavioural targets behind the decoder, prompt or slow, error on command
`timescale 1ns/1ps
`default_nettype none
module ard_tgt_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tgt_req,
  input wire logic [31:0] tgt_addr,
  input wire logic [1:0] dly,
  input wire logic err_en,
  output logic tgt_ack,
  output logic tgt_err,
  output logic [31:0] tgt_rdata
);
  logic [1:0] cnt;
  logic [31:0] last;
  initial begin
    tgt_ack = 1'b0;
    tgt_err = 1'b0;
    last = 32'h0000_0000;
    tgt_rdata = 32'hFFFF_FFFF;
    cnt = 2'h0;
  end
  always @(posedge clk) begin
    #1;
    if (sys_rst || tgt_ack) begin
      // Data line no longer valid once the ack is gone
      tgt_ack = 1'b0;
      tgt_err = 1'b0;
      tgt_rdata = ~last;
      cnt = 2'h0;
    end else if (tgt_req && cnt == dly) begin
      // Access completes at the target only here
      tgt_ack = 1'b1;
      tgt_err = err_en;
      last = tgt_addr ^ 32'h5A5A_A5A5;
      tgt_rdata = last;
    end else if (tgt_req) begin
      cnt = cnt + 2'h1;
    end
  end
endmodule // ard_tgt_model
`default_nettype wire

//--- test/tb_address_region_attribute_decoder.sv
// Self-checking bench for the region decoder with a target model
`timescale 1ns/1ps
`default_nettype none
`include "ard_defs.vh"
module tb_address_region_attribute_decoder;
  logic clk, sys_rst, mpu_enable, dbus_mpu_hit, dbus_mpu_xn, ibus_req, exec_valid, exec_xn_tag;
  logic dbus_req, dbus_write, data_memory_barrier, data_sync_barrier, instruction_sync_barrier;
  logic ibus_done, ibus_fault, ibus_xn_tag, exec_fault, dbus_done, dbus_fault, barrier_done;
  logic exec_hold, fetch_flush, prio_commit, posted_err, tgt_req, tgt_write, tgt_ack, tgt_err;
  logic err_en;
  logic [1:0] dbus_mpu_type, tgt_type, dly, seen_type;
  logic [2:0] tgt_region;
  logic [31:0] ibus_addr, dbus_addr, dbus_wdata, ibus_rdata, dbus_rdata, tgt_addr, tgt_wdata;
  logic [31:0] tgt_rdata, rnd, a, wd;
  logic [33:0] e;
  logic [33:0] dq[$], iq[$];
  int error_cnt, checks_done;
  logic [31:0] tab [12] = '{32'h0000_0000, 32'h2000_0000, 32'h2200_0000, 32'h4000_0000,
    32'h4200_0000, 32'hE000_E000, 32'h0004_0000, 32'h2001_0000, 32'h4400_0000,
    32'h6000_0000, 32'hE000_3000, 32'hF000_0000};
  ard_top uut (.clk(clk), .sys_rst(sys_rst), .mpu_enable(mpu_enable), .ibus_mpu_hit(1'b0),
    .ibus_mpu_type(2'h0), .ibus_mpu_xn(1'b0), .dbus_mpu_hit(dbus_mpu_hit),
    .dbus_mpu_type(dbus_mpu_type), .dbus_mpu_xn(dbus_mpu_xn), .ibus_req(ibus_req),
    .ibus_addr(ibus_addr), .ibus_done(ibus_done), .ibus_fault(ibus_fault),
    .ibus_xn_tag(ibus_xn_tag), .ibus_rdata(ibus_rdata), .exec_valid(exec_valid),
    .exec_xn_tag(exec_xn_tag), .exec_fault(exec_fault), .dbus_req(dbus_req),
    .dbus_addr(dbus_addr), .dbus_write(dbus_write), .dbus_wdata(dbus_wdata),
    .dbus_done(dbus_done), .dbus_fault(dbus_fault), .dbus_rdata(dbus_rdata),
    .data_memory_barrier(data_memory_barrier), .data_sync_barrier(data_sync_barrier),
    .instruction_sync_barrier(instruction_sync_barrier), .barrier_done(barrier_done),
    .exec_hold(exec_hold), .fetch_flush(fetch_flush), .prio_commit(prio_commit),
    .posted_err(posted_err), .tgt_req(tgt_req), .tgt_addr(tgt_addr), .tgt_write(tgt_write),
    .tgt_wdata(tgt_wdata), .tgt_region(tgt_region), .tgt_type(tgt_type), .tgt_ack(tgt_ack),
    .tgt_err(tgt_err), .tgt_rdata(tgt_rdata));
  ard_tgt_model u_tgt (.clk(clk), .sys_rst(sys_rst), .tgt_req(tgt_req), .tgt_addr(tgt_addr),
    .dly(dly), .err_en(err_en), .tgt_ack(tgt_ack), .tgt_err(tgt_err), .tgt_rdata(tgt_rdata));
  function automatic logic [31:0] rnd_next();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Drops the request after done and lets an edge pass; calls may follow at once
  task automatic xfer(input logic ib, input logic [31:0] ad, input logic w, input logic f);
    int n;
    logic [31:0] d;
    d = rnd_next();
    dly = d[5:4];
    if (ib) begin
      ibus_req = 1'b1;
      ibus_addr = ad;
      iq.push_back({w, f, w ? 32'h0000_0000 : ad ^ 32'h5A5A_A5A5});
    end else begin
      dbus_req = 1'b1;
      dbus_addr = ad;
      dbus_write = w;
      dbus_wdata = d;
      if (w) wd = d;
      dq.push_back({w, f, ad ^ 32'h5A5A_A5A5});
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      #1;
      if ((ib ? ibus_done : dbus_done) === 1'b1) break;
    end
    if (n == 50) begin
      error_cnt++;
      close_out();
    end
    // Request stands through the edge that samples done and drops before the next, else it is taken again
    @(posedge clk);
    #1;
    if (ib)
      ibus_req = 1'b0;
    else
      dbus_req = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic bar(input int k, input logic fl, input logic pc);
    int n;
    ibus_req = 1'b0;
    dbus_req = 1'b0;
    data_memory_barrier = k == 0;
    data_sync_barrier = k == 1;
    instruction_sync_barrier = k == 2;
    @(posedge clk);
    #1;
    {data_memory_barrier, data_sync_barrier, instruction_sync_barrier} = 3'h0;
    for (n = 0; n < 60 && barrier_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("barrier_done", barrier_done, 1'b1);
    chk("fetch_flush", fetch_flush, fl);
    chk("prio_commit", prio_commit, pc);
    @(posedge clk);
    #1;
  endtask
  always @(negedge clk) begin
    if (dbus_done === 1'b1) begin
      e = dq.size() ? dq.pop_front() : 34'h3_FFFF_FFFF;
      chk("dbus_fault", dbus_fault, e[32]);
      if (!e[33] && !e[32]) chk("dbus_rdata", dbus_rdata, e[31:0]);
    end
    if (ibus_done === 1'b1) begin
      e = iq.size() ? iq.pop_front() : 34'h3_FFFF_FFFF;
      chk("ibus_xn_tag", ibus_xn_tag, e[33]);
      chk("ibus_fault", ibus_fault, e[32]);
      if (!e[32]) chk("ibus_rdata", ibus_rdata, e[31:0]);
    end
    if (tgt_ack === 1'b1) seen_type = tgt_type;
    if (tgt_ack === 1'b1 && tgt_write === 1'b1) chk("tgt_wdata", tgt_wdata, wd);
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {sys_rst, mpu_enable, dbus_mpu_hit, dbus_mpu_xn, ibus_req, exec_valid, exec_xn_tag} = 7'h40;
    {dbus_req, dbus_write, data_memory_barrier, data_sync_barrier} = 4'h0;
    {instruction_sync_barrier, err_en, dbus_mpu_type, dly} = 6'h00;
    {ibus_addr, dbus_addr, dbus_wdata} = 96'h0;
    rnd = 32'h0000_2C3A;
    error_cnt = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 12; i++) begin
      a = tab[i] | (rnd_next() & 32'h0000_0FFC);
      xfer(0, a, 0, i > 5);
      xfer(0, a, 1, i > 5);
      // Execute-never holes answer with the tag; only executable holes fault
      xfer(1, a, i inside {3, 4, 5, 8, 10, 11}, i inside {6, 7, 9});
      exec_valid = 1'b1;
      exec_xn_tag = rnd[7];
      @(posedge clk);
      #1;
      exec_valid = 1'b0;
      chk("exec_fault", exec_fault, exec_xn_tag);
    end
    xfer(0, 32'h4000_4000, 1, 0);
    bar(0, 0, 0);
    bar(1, 0, 1);
    bar(2, 1, 0);
    err_en = 1'b1;
    xfer(0, 32'h4000_C000, 1, 0);
    dbus_req = 1'b0;
    for (int n = 0; n < 20 && posted_err !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("posted_err", posted_err, 1);
    err_en = 1'b0;
    // Override type differs from both the default and the last drained write
    {mpu_enable, dbus_mpu_hit, dbus_mpu_xn, dbus_mpu_type} = {3'h7, `ARD_TYPE_STRONG};
    xfer(0, 32'h2000_0100, 0, 0);
    chk("mpu type", 32'(seen_type), 32'(`ARD_TYPE_STRONG));
    xfer(0, 32'h0004_0000, 0, 1);
    dbus_req = 1'b0;
    mpu_enable = 1'b0;
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule // tb_address_region_attribute_decoder
bind ard_top ard_checker u_chk (.clk(clk), .sys_rst(sys_rst), .mpu_enable(mpu_enable),
  .ibus_req(ibus_req), .ibus_addr(ibus_addr), .ibus_done(ibus_done),
  .ibus_xn_tag(ibus_xn_tag), .exec_valid(exec_valid), .exec_xn_tag(exec_xn_tag),
  .exec_fault(exec_fault), .dbus_req(dbus_req), .dbus_addr(dbus_addr),
  .dbus_write(dbus_write), .dbus_done(dbus_done), .dbus_fault(dbus_fault),
  .data_sync_barrier(data_sync_barrier), .instruction_sync_barrier(instruction_sync_barrier),
  .barrier_done(barrier_done), .exec_hold(exec_hold), .fetch_flush(fetch_flush),
  .tgt_req(tgt_req), .tgt_addr(tgt_addr), .tgt_region(tgt_region), .tgt_type(tgt_type),
  .tgt_ack(tgt_ack));
`default_nettype wire
